// File: bench/pgwd_checker.sv
// checker: watchdog port assertions
`timescale 1ns/10ps
module pgwd_checker (
    input wire logic        ref_clk,   // clock
    input wire logic        sys_rst,   // reset
    input wire logic [15:0] bus_addr,  // addr
    input wire logic        bus_wr,    // write
    input wire logic        bus_rd,    // read
    input wire logic [15:0] bus_wdata, // wdata
    input wire logic [15:0] bus_rdata, // rdata
    input wire logic        puc_rst,   // puc
    input wire logic        irq,       // irq
    input wire logic        nmi_en,    // nmi
    input wire logic        nmi_edge   // edge
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire sel = bus_addr == 16'h0120;
    wire gwr = bus_wr && sel && bus_wdata[15:8] == 8'h5A;
    // ==================================================
    // port relations
    bad_key_a: assert property (bus_wr && sel && !gwr |=> puc_rst)
        else $error("no puc on bad key");
    good_key_a: assert property (gwr |=> !puc_rst)
        else $error("puc on good key");
    rd_key_a: assert property (
        bus_rd && sel |=> bus_rdata[15:8] == 8'h69)
        else $error("read key wrong");
    rd_idle_a: assert property (!(bus_rd && sel) |=> bus_rdata == 16'h0000)
        else $error("rdata not idle");
    nmi_cfg_a: assert property (gwr && !puc_rst && !$past(puc_rst)
        && !$past(puc_rst, 2)
        |=> {nmi_edge, nmi_en} == $past(bus_wdata[6:5]))
        else $error("nmi bits wrong");
    puc_pulse_a: assert property (puc_rst |=> !puc_rst)
        else $error("puc too long");
    irq_pulse_a: assert property (irq |=> !irq)
        else $error("irq too long");
    nmi_hold_a: assert property (!bus_wr && !puc_rst && !$past(puc_rst)
        |=> $stable({nmi_edge, nmi_en}))
        else $error("nmi bits moved");
endmodule // pgwd_checker
bind pgwd_top pgwd_checker u_chk (.ref_clk, .sys_rst, .bus_addr, .bus_wr,
    .bus_rd, .bus_wdata, .bus_rdata, .puc_rst, .irq, .nmi_en, .nmi_edge);

// File: bench/pgwd_tb_top.sv
// bench: self-checking watchdog test
`timescale 1ns/10ps
module pgwd_tb_top;
    logic        ref_clk = 0, sys_rst = 1, bus_wr = 0, bus_rd = 0;
    logic        puc_rst, irq, nmi_en, nmi_edge;
    logic [15:0] bus_addr = 16'h0120, bus_wdata = 16'h0000, bus_rdata;
    logic [15:0] r = 16'hB6F8;
    int          err_count = 0, check_count = 0, n, ctl;
    pgwd_top dut (.ref_clk, .sys_rst, .bus_addr, .bus_wr, .bus_rd,
        .bus_wdata, .bus_rdata, .puc_rst, .irq, .nmi_en, .nmi_edge);
    initial forever #10 ref_clk = ~ref_clk;
    function automatic logic [15:0] xs(logic [15:0] v);
        v ^= v << 7;
        v ^= v >> 9;
        v ^= v << 8;
        return v;
    endfunction
    task automatic chk(logic [15:0] g, logic [15:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic acc(logic w, logic [15:0] a, logic [15:0] d);
        @(negedge ref_clk);
        {bus_wr, bus_rd, bus_addr, bus_wdata} = {w, !w, a, d};
        @(negedge ref_clk);
        {bus_wr, bus_rd} = 2'b00;
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge ref_clk);
        sys_rst = 0;
        acc(0, 16'h0120, 16'h0000);
        chk(bus_rdata, 16'h6900);
        acc(1, 16'h0120, 16'h5A6B);
        chk({nmi_edge, nmi_en}, 16'h0003);
        acc(0, 16'h0120, 16'h0000);
        chk(bus_rdata, 16'h6963);
        for (n = 0; n < 80 && puc_rst !== 1'b1; n++) @(negedge ref_clk);
        chk(n > 50 && n < 80, 16'h0001);
        if (n >= 80) conclude();
        repeat (4) @(negedge ref_clk);
        acc(1, 16'h0120, 16'h5A1B);
        n = 0;
        repeat (150) @(negedge ref_clk) n += irq + 16 * puc_rst;
        chk(n, 16'h0002);
        repeat (4) begin
            r = xs(r);
            ctl = r[7:0] & 8'hF7;
            acc(1, 16'h0120, {8'h5A, r[7:0] | 8'h08});
            acc(0, 16'h0120, 16'h0000);
            chk(bus_rdata, 16'h6900 | ctl);
        end
        acc(1, 16'h0122, 16'h1234);
        chk(puc_rst, 16'h0000);
        acc(1, 16'h0120, {r[15:8] == 8'h5A ? 8'h00 : r[15:8], 8'h80});
        chk(puc_rst, 16'h0001);
        repeat (4) @(negedge ref_clk);
        acc(0, 16'h0120, 16'h0000);
        chk(bus_rdata, 16'h6900);
        conclude();
    end
endmodule // pgwd_tb_top

// File: hw/pgwd_top.sv
// module: password guarded watchdog and interval timer
`timescale 1ns/10ps

// What this block does
// - watchdog mode: interval end resets system
// - timer mode: interval end raises interrupt
// - hidden 16-bit up-counter, control word only
// - key 5A in high byte stores low byte
// - wrong key triggers power-up-clear reset
// - read returns 69 in high byte
// - 8-bit control setting readable and writable
// - two control bits configure nmi pin
// - control word at word address 0120
module pgwd_top (
    input  wire logic                          ref_clk,   // 50 MHz clock
    input  wire logic                          sys_rst,   // async reset
    input  wire logic [pgwd_pkg::PGWD_ADDR_W-1:0] bus_addr, // word address
    input  wire logic                          bus_wr,    // write strobe
    input  wire logic                          bus_rd,    // read strobe
    input  wire logic [pgwd_pkg::PGWD_DATA_W-1:0] bus_wdata, // write data
    output logic      [pgwd_pkg::PGWD_DATA_W-1:0] bus_rdata, // read data
    output logic                               puc_rst,   // system reset
    output logic                               irq,       // interval pulse
    output logic                               nmi_en,    // nmi pin mode
    output logic                               nmi_edge   // nmi edge select
);
    import pgwd_pkg::*;

    // =========================================================
    // state
    logic [7:0]            ctl_r,   ctl_nxt;
    logic [PGWD_CNT_W-1:0] cnt_r,   cnt_nxt;
    logic [15:0]           rdat_r,  rdat_nxt;
    logic                  puc_r,   puc_nxt;
    logic                  irq_r,   irq_nxt;
    logic [1:0]            hold_r,  hold_nxt;

    // tap position of the selected interval
    function automatic logic expired(input logic [PGWD_CNT_W-1:0] c,
                                     input logic [1:0] sel);
        unique case (sel)
            2'h0:    expired = &c[15:0];
            2'h1:    expired = &c[12:0];
            2'h2:    expired = &c[8:0];
            default: expired = &c[5:0];
        endcase
    endfunction

    // the clear-down after a power-up-clear is running
    function automatic logic clearing(input logic [1:0] h);
        clearing = h != 2'h0;
    endfunction

    logic hit, wr_sel, key_ok, wr_take, wr_bad, tick;

    // =========================================================
    // bus decode
    always_comb begin
        hit     = bus_addr == PGWD_CTL_ADDR;
        wr_sel  = bus_wr && hit;
        key_ok  = bus_wdata[15:8] == PGWD_WR_KEY;
        // keyed writes are dropped while the clear-down runs
        wr_take = wr_sel && key_ok && !clearing(hold_r);
        // any other key is a violation
        wr_bad  = wr_sel && !key_ok;
    end

    // =========================================================
    // interval detect
    always_comb begin
        // a keyed write in the same cycle wins over expiry
        tick = !clearing(hold_r)
               && !ctl_r[PGWD_HOLD_BIT]
               && !wr_take
               && expired(cnt_r, ctl_r[PGWD_SEL_MSB:PGWD_SEL_LSB]);
    end

    // =========================================================
    // control setting
    always_comb begin
        ctl_nxt = ctl_r;
        if (wr_take) begin
            ctl_nxt = bus_wdata[7:0];
            // clear request is a strobe and reads back as zero
            ctl_nxt[PGWD_CLR_BIT] = 1'b0;
        end
        // power-up-clear restores the setting
        if (clearing(hold_r)) begin
            ctl_nxt = PGWD_CTL_RST;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl_r <= PGWD_CTL_RST;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    // =========================================================
    // guard counter
    always_comb begin
        cnt_nxt = cnt_r;
        if (!ctl_r[PGWD_HOLD_BIT]) begin
            cnt_nxt = cnt_r + 16'h0001;
        end
        // each interval restarts from zero
        if (tick) begin
            cnt_nxt = PGWD_CNT_RST;
        end
        if (wr_take && bus_wdata[PGWD_CLR_BIT]) begin
            cnt_nxt = PGWD_CNT_RST;
        end
        if (clearing(hold_r)) begin
            cnt_nxt = PGWD_CNT_RST;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= PGWD_CNT_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // =========================================================
    // interval events
    always_comb begin
        irq_nxt = 1'b0;
        puc_nxt = 1'b0;
        if (tick) begin
            if (ctl_r[PGWD_TMSEL_BIT]) begin
                irq_nxt = 1'b1;
            end else begin
                puc_nxt = 1'b1;
            end
        end
        if (wr_bad) begin
            puc_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            puc_r <= 1'b0;
        end else begin
            puc_r <= puc_nxt;
        end
    end

    // =========================================================
    // clear-down after a power-up-clear
    always_comb begin
        hold_nxt = hold_r;
        // a new violation restarts the full clear-down
        if (puc_nxt) begin
            hold_nxt = PGWD_RST_HOLD;
        end else if (clearing(hold_r)) begin
            hold_nxt = hold_r - 2'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_r <= 2'h0;
        end else begin
            hold_r <= hold_nxt;
        end
    end

    // =========================================================
    // read port
    always_comb begin
        if (bus_rd && hit) begin
            rdat_nxt = {PGWD_RD_KEY, ctl_r};
        end else begin
            rdat_nxt = 16'h0000;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdat_r <= 16'h0000;
        end else begin
            rdat_r <= rdat_nxt;
        end
    end

    // =========================================================
    // outputs
    assign bus_rdata = rdat_r;
    assign puc_rst   = puc_r;
    assign irq       = irq_r;
    assign nmi_en    = ctl_r[PGWD_NMI_BIT];
    assign nmi_edge  = ctl_r[PGWD_NMIES_BIT];

endmodule // pgwd_top

// File: shared/pgwd_pkg.sv
// package: constants for the password guarded watchdog
package pgwd_pkg;
    // =========================================================
    // bus and register map
    localparam int          PGWD_ADDR_W      = 16;
    localparam int          PGWD_DATA_W      = 16;
    localparam logic [15:0] PGWD_CTL_ADDR    = 16'h0120;
    localparam logic [7:0]  PGWD_WR_KEY      = 8'h5A;
    localparam logic [7:0]  PGWD_RD_KEY      = 8'h69;
    localparam logic [7:0]  PGWD_CTL_RST     = 8'h00;
    // =========================================================
    // control field positions
    localparam int          PGWD_SEL_LSB     = 0;
    localparam int          PGWD_SEL_MSB     = 1;
    localparam int          PGWD_CLR_BIT     = 3;
    localparam int          PGWD_TMSEL_BIT   = 4;
    localparam int          PGWD_NMI_BIT     = 5;
    localparam int          PGWD_NMIES_BIT   = 6;
    localparam int          PGWD_HOLD_BIT    = 7;
    // =========================================================
    // counter
    localparam int          PGWD_CNT_W       = 16;
    localparam logic [15:0] PGWD_CNT_RST     = 16'h0000;
    localparam logic [1:0]  PGWD_RST_HOLD    = 2'h3;
endpackage
